// File: pkg/nde_pkg.sv
// Package: register map, field positions, reset values and timing of the NVM block
package nde_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] NDE_OFS_DATA   = 8'h08;
  localparam logic [7:0] NDE_OFS_ADDR   = 8'h09;
  localparam logic [7:0] NDE_OFS_IRQ    = 8'h0B;
  localparam logic [7:0] NDE_OFS_CTRL   = 8'h88;
  localparam logic [7:0] NDE_OFS_UNLOCK = 8'h89;

  // nvm_ctrl_reg fields
  localparam int NDE_CTRL_RD     = 0;
  localparam int NDE_CTRL_WR     = 1;
  localparam int NDE_CTRL_UNLOCK = 2;
  localparam int NDE_CTRL_ABORT  = 3;
  localparam int NDE_CTRL_DONE   = 4;

  // irq_ctrl_reg fields
  localparam int NDE_IRQ_PORT_FLAG = 0;
  localparam int NDE_IRQ_EXT_FLAG  = 1;
  localparam int NDE_IRQ_TMR_FLAG  = 2;
  localparam int NDE_IRQ_PORT_EN   = 3;
  localparam int NDE_IRQ_EXT_EN    = 4;
  localparam int NDE_IRQ_TMR_EN    = 5;
  localparam int NDE_IRQ_NVM_EN    = 6;
  localparam int NDE_IRQ_GLOBAL    = 7;

  // Unlock keys, in order
  localparam logic [7:0] NDE_KEY_FIRST  = 8'h55;
  localparam logic [7:0] NDE_KEY_SECOND = 8'hAA;

  // Reset values
  localparam logic [7:0] NDE_DATA_RST = 8'h00;
  localparam logic [7:0] NDE_ADDR_RST = 8'h00;
  localparam logic [7:0] NDE_IRQ_RST  = 8'h00;
  localparam logic [7:0] NDE_RDATA_RST = 8'h00;

  // Array geometry
  localparam int NDE_ARR_AW    = 6;
  localparam int NDE_ARR_DEPTH = 64;

  // Timing: programming time in ns, clock period in ps
  localparam int NDE_CLK_PERIOD_PS = 4000;
  localparam int NDE_PROG_TIME_NS  = 2000;
  localparam int NDE_PROG_CYCLES   =
    (NDE_PROG_TIME_NS * 1000 + NDE_CLK_PERIOD_PS - 1) / NDE_CLK_PERIOD_PS;
  localparam int NDE_CNT_W = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } nde_bus_req_t;

  typedef struct packed {
    logic timer_ovf;
    logic ext_pin;
    logic port_change;
  } nde_irq_src_t;

  typedef enum logic [2:0] {
    NDE_SEQ_IDLE  = 3'h1,
    NDE_SEQ_KEY1  = 3'h2,
    NDE_SEQ_ARMED = 3'h4
  } nde_seq_t;

endpackage

// File: src/nde_array.sv
// Byte-wide 64-location data array with one write and one read port
`timescale 1ns/10ps
module nde_array
  import nde_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  we_i,
  input  wire logic [NDE_ARR_AW-1:0] waddr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic [NDE_ARR_AW-1:0] raddr_i,
  output      logic [7:0]            rdata_o
);

  // No reset: cells keep their contents like the real array
  logic [7:0] mem [NDE_ARR_DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read is combinational so the data register loads in one edge
  assign rdata_o = mem[raddr_i];

endmodule

// File: src/nde_ctrl.sv
// NVM data array controller with unlock sequence and interrupt control register
//
// Notes on behaviour
// - Read strobe while not busy loads data register next cycle
// - Data register holds until read or write
// - Write needs 55h, AAh, then start bit
// - Start bit blocked while unlock bit clear
// - Unlock bit changes only by software
// - Launched write completes despite unlock cleared
// - Finish clears start bit, sets done flag
// - Done flag sticks until software clears
// - Flags set regardless of any enable
// - Bit 7 global enable gates all interrupts
// - Bit 6 enables write-complete interrupt
// - Bit 5 timer enable, bit 2 flag
// - Bit 4 pin enable, bit 1 flag
// - Bit 3 port enable, bit 0 flag
// - Control layout fixed, bits 7..5 read zero
// - Data and address survive non-power-on resets
`timescale 1ns/10ps
module nde_ctrl
  import nde_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = NDE_PROG_CYCLES
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         por_i,
  input  wire nde_bus_req_t bus_i,
  output      logic [7:0]   rdata_o,
  input  wire nde_irq_src_t src_i,
  output      logic         irq_o
);

  localparam logic [NDE_CNT_W-1:0] CNT_LOAD = NDE_CNT_W'(PROG_CYCLES - 1);

  function automatic logic wr_hit(input nde_bus_req_t b, input logic [7:0] ofs);
    wr_hit = b.we && (b.addr == ofs);
  endfunction

  logic                 any_rst;
  nde_seq_t             seq_r;
  logic [7:0]           data_r;
  logic [7:0]           addr_r;
  logic [7:0]           irq_r;
  logic [7:0]           irq_nxt;
  logic                 busy_r;
  logic [NDE_CNT_W-1:0] cnt_r;
  logic                 unlock_r;
  logic                 abort_r;
  logic                 done_r;
  logic [7:0]           prog_data_r;
  logic [7:0]           prog_addr_r;
  logic [7:0]           arr_rdata;
  logic                 ctrl_wr;
  logic                 rd_req;
  logic                 start;
  logic                 finish;

  assign any_rst = rst_i || por_i;
  assign ctrl_wr = wr_hit(bus_i, NDE_OFS_CTRL);

  // Array is busy while programming, so reads wait for software to retry
  assign rd_req = ctrl_wr && bus_i.wdata[NDE_CTRL_RD] && !busy_r;
  assign start  = ctrl_wr && bus_i.wdata[NDE_CTRL_WR] && !busy_r
                  && (seq_r == NDE_SEQ_ARMED) && unlock_r;
  assign finish = busy_r && (cnt_r == '0);

  nde_array u_array (
    .clk_i   (clk_i),
    .we_i    (finish),
    .waddr_i (prog_addr_r[NDE_ARR_AW-1:0]),
    .wdata_i (prog_data_r),
    .raddr_i (addr_r[NDE_ARR_AW-1:0]),
    .rdata_o (arr_rdata)
  );

  // Unlock sequence; any other write in between drops it, except a repeated first key, which holds it after the first key
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      seq_r <= NDE_SEQ_IDLE;
    end
    else if (bus_i.we)
    begin
      unique case (seq_r)
        NDE_SEQ_IDLE:
        begin
          if (wr_hit(bus_i, NDE_OFS_UNLOCK) && bus_i.wdata == NDE_KEY_FIRST)
            seq_r <= NDE_SEQ_KEY1;
        end
        NDE_SEQ_KEY1:
        begin
          if (wr_hit(bus_i, NDE_OFS_UNLOCK) && bus_i.wdata == NDE_KEY_SECOND)
            seq_r <= NDE_SEQ_ARMED;
          else if (wr_hit(bus_i, NDE_OFS_UNLOCK) && bus_i.wdata == NDE_KEY_FIRST)
            seq_r <= NDE_SEQ_KEY1;
          else
            seq_r <= NDE_SEQ_IDLE;
        end
        NDE_SEQ_ARMED:
        begin
          seq_r <= NDE_SEQ_IDLE;
        end
        default:
        begin
          seq_r <= NDE_SEQ_IDLE;
        end
      endcase
    end
  end

  // Data and address only clear at power-on
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      data_r <= NDE_DATA_RST;
    end
    else if (rd_req)
    begin
      data_r <= arr_rdata;
    end
    else if (wr_hit(bus_i, NDE_OFS_DATA))
    begin
      data_r <= bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      addr_r <= NDE_ADDR_RST;
    end
    else if (wr_hit(bus_i, NDE_OFS_ADDR))
    begin
      addr_r <= bus_i.wdata;
    end
  end

  // Programming timer; snapshot keeps later register writes out of this cycle
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
    end
    else if (start)
    begin
      busy_r <= 1'b1;
      cnt_r  <= CNT_LOAD;
    end
    else if (finish)
    begin
      busy_r <= 1'b0;
    end
    else if (busy_r)
    begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (start)
    begin
      prog_data_r <= data_r;
      prog_addr_r <= addr_r;
    end
  end

  // Unlock bit: no hardware path clears it
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      unlock_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      unlock_r <= bus_i.wdata[NDE_CTRL_UNLOCK];
    end
  end

  // Abort flag: a warm reset that cuts a write short marks it
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      abort_r <= 1'b0;
    end
    else if (rst_i)
    begin
      abort_r <= abort_r || busy_r;
    end
    else if (ctrl_wr)
    begin
      abort_r <= bus_i.wdata[NDE_CTRL_ABORT];
    end
  end

  // Done flag: hardware set wins over a software clear
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      done_r <= 1'b0;
    end
    else if (finish)
    begin
      done_r <= 1'b1;
    end
    else if (ctrl_wr)
    begin
      done_r <= bus_i.wdata[NDE_CTRL_DONE];
    end
  end

  // Interrupt control: enables by software, flags set by events
  always_comb
  begin
    irq_nxt = irq_r;
    if (wr_hit(bus_i, NDE_OFS_IRQ))
    begin
      irq_nxt = bus_i.wdata;
    end
    if (src_i.timer_ovf)
    begin
      irq_nxt[NDE_IRQ_TMR_FLAG] = 1'b1;
    end
    if (src_i.ext_pin)
    begin
      irq_nxt[NDE_IRQ_EXT_FLAG] = 1'b1;
    end
    if (src_i.port_change)
    begin
      irq_nxt[NDE_IRQ_PORT_FLAG] = 1'b1;
    end
  end

  // Port-change flag clears at power-on; warm reset leaves it
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      irq_r <= NDE_IRQ_RST;
    end
    else if (rst_i)
    begin
      irq_r <= {NDE_IRQ_RST[7:1], irq_r[NDE_IRQ_PORT_FLAG]};
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  assign irq_o = irq_r[NDE_IRQ_GLOBAL] && (
                   (irq_r[NDE_IRQ_NVM_EN]  && done_r) ||
                   (irq_r[NDE_IRQ_TMR_EN]  && irq_r[NDE_IRQ_TMR_FLAG]) ||
                   (irq_r[NDE_IRQ_EXT_EN]  && irq_r[NDE_IRQ_EXT_FLAG]) ||
                   (irq_r[NDE_IRQ_PORT_EN] && irq_r[NDE_IRQ_PORT_FLAG]));

  // Read data one cycle after the strobe; unmapped and unlock read zero
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      rdata_o <= NDE_RDATA_RST;
    end
    else if (bus_i.re)
    begin
      unique case (bus_i.addr)
        NDE_OFS_DATA: rdata_o <= data_r;
        NDE_OFS_ADDR: rdata_o <= addr_r;
        NDE_OFS_IRQ:  rdata_o <= irq_r;
        NDE_OFS_CTRL: rdata_o <= {3'h0, done_r, abort_r, unlock_r, busy_r, 1'b0};
        default:      rdata_o <= 8'h00;
      endcase
    end
    else
    begin
      rdata_o <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (any_rst);

  a_read_next_cycle: assert property (
    rd_req |=> data_r == $past(arr_rdata))
    else $error("data register missed the array byte");

  a_data_hold: assert property (
    !rd_req && !wr_hit(bus_i, NDE_OFS_DATA) |=> $stable(data_r))
    else $error("data register changed without cause");

  a_start_after_keys: assert property (
    $rose(busy_r) |-> $past(seq_r) == NDE_SEQ_ARMED
                      && $past(ctrl_wr) && $past(bus_i.wdata[NDE_CTRL_WR]))
    else $error("write began without the unlock keys");

  a_start_needs_unlock: assert property (
    $rose(busy_r) |-> $past(unlock_r))
    else $error("write began with unlock bit clear");

  a_unlock_sw_only: assert property (
    !ctrl_wr |=> $stable(unlock_r))
    else $error("unlock bit moved without software");

  a_write_runs_on: assert property (
    busy_r && cnt_r != '0 |=> busy_r && cnt_r == $past(cnt_r) - 1'b1)
    else $error("write cycle cut short");

  a_finish_effects: assert property (
    finish |=> !busy_r && done_r)
    else $error("finish did not clear start and set done");

  a_done_sticky: assert property (
    done_r && !(ctrl_wr && !bus_i.wdata[NDE_CTRL_DONE]) |=> done_r)
    else $error("done flag dropped on its own");

  a_timer_flag_set: assert property (
    src_i.timer_ovf |=> irq_r[NDE_IRQ_TMR_FLAG])
    else $error("timer flag not set");

  a_pin_flag_set: assert property (
    src_i.ext_pin |=> irq_r[NDE_IRQ_EXT_FLAG])
    else $error("pin flag not set");

  a_port_flag_set: assert property (
    src_i.port_change |=> irq_r[NDE_IRQ_PORT_FLAG])
    else $error("port flag not set");

  a_global_gate: assert property (
    !irq_r[NDE_IRQ_GLOBAL] |-> !irq_o)
    else $error("interrupt passed with global enable off");

  a_nvm_irq: assert property (
    irq_r[NDE_IRQ_GLOBAL] && irq_r[NDE_IRQ_NVM_EN] && done_r |-> irq_o)
    else $error("write-complete interrupt not raised");

  a_ctrl_readback: assert property (
    bus_i.re && bus_i.addr == NDE_OFS_CTRL
    |=> rdata_o[7:5] == 3'h0 && rdata_o[NDE_CTRL_WR] == $past(busy_r))
    else $error("control register read back wrong");

  a_no_read_busy: assert property (
    busy_r && !wr_hit(bus_i, NDE_OFS_DATA)
    |=> $stable(data_r) && $stable(prog_addr_r) && $stable(prog_data_r))
    else $error("array touched while programming");

  c_write_done: cover property (start ##[1:1000] finish);
  c_read: cover property (rd_req ##1 bus_i.re && bus_i.addr == NDE_OFS_DATA);
  c_bad_key: cover property (seq_r == NDE_SEQ_KEY1 ##1 seq_r == NDE_SEQ_IDLE);
  c_irq: cover property ($rose(irq_o));

endmodule

// File: verification/nde_tb.sv
// Self-checking testbench for the NVM controller and its interrupt register
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t ns: got %h expected %h", $time, g, e); end end
module testbench
  import nde_pkg::*;
;
  // Short programming time keeps the run brief
  localparam int PROG = 8;

  logic         clk_i;
  logic         rst_i;
  logic         por_i;
  nde_bus_req_t bus_i;
  logic [7:0]   rdata_o;
  nde_irq_src_t src_i;
  logic         irq_o;
  int           err_total;
  int           checks_done;
  logic [7:0]   v;

  nde_ctrl #(.PROG_CYCLES(PROG)) u_nde_ctrl (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .por_i   (por_i),
    .bus_i   (bus_i),
    .rdata_o (rdata_o),
    .src_i   (src_i),
    .irq_o   (irq_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One-cycle write strobe, one idle cycle after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus_i.we <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus_i.re <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] got;
    rd(a, got);
    `CHK(got, e)
  endtask

  // Interrupts masked around the keys, then restored
  task automatic launch(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] ie;
    rd(NDE_OFS_IRQ, ie);
    wr(NDE_OFS_IRQ, ie & 8'h7F);
    wr(NDE_OFS_ADDR, a);
    wr(NDE_OFS_DATA, d);
    wr(NDE_OFS_CTRL, 8'h04);
    wr(NDE_OFS_UNLOCK, NDE_KEY_FIRST);
    wr(NDE_OFS_UNLOCK, NDE_KEY_SECOND);
    wr(NDE_OFS_CTRL, 8'h06);
    wr(NDE_OFS_IRQ, ie);
  endtask

  // Polls the done flag; a hang ends the run
  task automatic wait_done();
    for (int i = 0; i < 100; i++)
    begin
      rd(NDE_OFS_CTRL, v);
      if (v[NDE_CTRL_DONE] === 1'b1)
        return;
    end
    err_total++;
    $display("[FAIL] %0t ns: write never finished", $time);
    results();
  endtask

  task automatic t_reset();
    rchk(NDE_OFS_CTRL, 8'h00);
    rchk(NDE_OFS_IRQ, 8'h00);
    rchk(NDE_OFS_UNLOCK, 8'h00);
    rchk(8'h30, 8'h00);
    $display("reset values done");
  endtask

  task automatic t_write_read();
    launch(8'h05, 8'hA5);
    rchk(NDE_OFS_CTRL, 8'h06);
    wait_done();
    rchk(NDE_OFS_CTRL, 8'h14);
    rchk(NDE_OFS_CTRL, 8'h14);
    wr(NDE_OFS_CTRL, 8'h04);
    rchk(NDE_OFS_CTRL, 8'h04);
    wr(NDE_OFS_DATA, 8'h00);
    // Upper address bits must not reach the array
    wr(NDE_OFS_ADDR, 8'h45);
    wr(NDE_OFS_CTRL, 8'h01);
    rchk(NDE_OFS_DATA, 8'hA5);
    rchk(NDE_OFS_DATA, 8'hA5);
    wr(NDE_OFS_DATA, 8'h3C);
    rchk(NDE_OFS_DATA, 8'h3C);
    rchk(NDE_OFS_CTRL, 8'h00);
    $display("write and read back done");
  endtask

  task automatic t_unlock_clear();
    launch(8'h06, 8'h5A);
    // Read strobe while busy must be ignored
    wr(NDE_OFS_CTRL, 8'h01);
    rchk(NDE_OFS_CTRL, 8'h02);
    rchk(NDE_OFS_DATA, 8'h5A);
    wait_done();
    rchk(NDE_OFS_CTRL, 8'h10);
    wr(NDE_OFS_IRQ, 8'hC0);
    `CHK(irq_o, 1'b1)
    wr(NDE_OFS_IRQ, 8'h40);
    `CHK(irq_o, 1'b0)
    wr(NDE_OFS_CTRL, 8'h00);
    wr(NDE_OFS_IRQ, 8'hC0);
    `CHK(irq_o, 1'b0)
    wr(NDE_OFS_DATA, 8'h00);
    wr(NDE_OFS_ADDR, 8'h06);
    wr(NDE_OFS_CTRL, 8'h01);
    rchk(NDE_OFS_DATA, 8'h5A);
    $display("unlock cleared mid-write done");
  endtask

  task automatic t_bad_seq();
    wr(NDE_OFS_ADDR, 8'h07);
    wr(NDE_OFS_CTRL, 8'h04);
    wr(NDE_OFS_UNLOCK, NDE_KEY_FIRST);
    wr(NDE_OFS_DATA, 8'h22);
    wr(NDE_OFS_UNLOCK, NDE_KEY_SECOND);
    wr(NDE_OFS_CTRL, 8'h06);
    rchk(NDE_OFS_CTRL, 8'h04);
    wr(NDE_OFS_CTRL, 8'h00);
    wr(NDE_OFS_UNLOCK, NDE_KEY_FIRST);
    wr(NDE_OFS_UNLOCK, NDE_KEY_SECOND);
    wr(NDE_OFS_CTRL, 8'h02);
    rchk(NDE_OFS_CTRL, 8'h00);
    $display("broken sequences done");
  endtask

  task automatic t_irq();
    wr(NDE_OFS_IRQ, 8'h00);
    @(posedge clk_i);
    src_i <= 3'h7;
    @(posedge clk_i);
    src_i <= 3'h0;
    rchk(NDE_OFS_IRQ, 8'h07);
    `CHK(irq_o, 1'b0)
    // Bit i flag pairs with enable bit i+3
    for (int i = 0; i < 3; i++)
    begin
      wr(NDE_OFS_IRQ, 8'h80 | (8'h08 << i) | (8'h01 << i));
      `CHK(irq_o, 1'b1)
      wr(NDE_OFS_IRQ, (8'h08 << i) | (8'h01 << i));
      `CHK(irq_o, 1'b0)
      wr(NDE_OFS_IRQ, 8'hB8 & ~(8'h08 << i) | (8'h01 << i));
      `CHK(irq_o, 1'b0)
    end
    wr(NDE_OFS_IRQ, 8'h00);
    $display("interrupt register done");
  endtask

  task automatic t_warm_reset();
    launch(8'h09, 8'h77);
    // Port flag must survive a warm reset, other bits clear
    wr(NDE_OFS_IRQ, 8'h09);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(NDE_OFS_CTRL, 8'h08);
    rchk(NDE_OFS_IRQ, 8'h01);
    rchk(NDE_OFS_ADDR, 8'h09);
    rchk(NDE_OFS_DATA, 8'h77);
    wr(NDE_OFS_CTRL, 8'h00);
    rchk(NDE_OFS_CTRL, 8'h00);
    $display("warm reset done");
  endtask

  initial
  begin
    err_total = 0;
    checks_done = 0;
    rst_i = 1'b1;
    por_i = 1'b1;
    bus_i = '0;
    src_i = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    t_reset();
    t_write_read();
    t_unlock_clear();
    t_bad_seq();
    t_irq();
    t_warm_reset();
    results();
  end
endmodule
